// >>> rtl/lmac_map.vh
`ifndef LMAC_MAP_VH
`define LMAC_MAP_VH

// Register byte offsets
`define LMAC_CTRL_OFS 4'h0
`define LMAC_STAT_OFS 4'h4
`define LMAC_MODE_OFS 4'h8

// Control fields
`define LMAC_CTRL_E3_LSB 0
`define LMAC_CTRL_STS1_LSB 4
`define LMAC_CTRL_AONE_LSB 8
`define LMAC_CTRL_RST 12'h000

// Status fields
`define LMAC_STAT_LOS_LSB 0
`define LMAC_STAT_LOL_LSB 4
`define LMAC_STAT_DRV_LSB 8
`define LMAC_STAT_HOST_BIT 12

// Mode readback fields
`define LMAC_MODE_E3_LSB 0
`define LMAC_MODE_STS1_LSB 4
`define LMAC_MODE_AONE_LSB 8

// Timing counts, in edges of the named clock; the lock tolerance in per mille of the window
`define LMAC_DRV_MON_CNT 128
`define LMAC_LOS_E3_ZEROS 32
`define LMAC_LOS_DS3_ZEROS 175
`define LMAC_LOL_WINDOW 2048
`define LMAC_LOL_TOL_PERMILLE 5

`endif

// >>> rtl/lmac_chan.v
`timescale 1ns/10ps
`include "lmac_map.vh"

module lmac_chan #(
    parameter DRV_CNT = `LMAC_DRV_MON_CNT
) (
    input wire clk,
    input wire sys_rst,
    input wire all_ones,
    input wire transmit_clock,
    input wire tx_data_pos,
    input wire tx_data_neg,
    input wire monitor_tip_input,
    input wire monitor_ring_input,
    output reg tx_line_pos,
    output reg tx_line_neg,
    output reg drive_failure_flag
);

reg tx_clk_prev_q;
reg mark_phase_q;
reg [7:0] idle_cnt_q;
wire tx_rise;
wire line_pulse;

assign tx_rise = transmit_clock & ~tx_clk_prev_q;
// A mark drives tip and ring apart; idle leaves both at the same level
assign line_pulse = monitor_tip_input ^ monitor_ring_input;

////////////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
    // Sampled through reset, so release brings no false edge
    tx_clk_prev_q <= transmit_clock;
    if (sys_rst) begin
        mark_phase_q <= 1'b0;
        tx_line_pos <= 1'b0;
        tx_line_neg <= 1'b0;
    end else begin
        if (tx_rise) begin
            if (all_ones) begin
                // Alternate polarity keeps the pattern AMI, one mark per period
                tx_line_pos <= ~mark_phase_q;
                tx_line_neg <= mark_phase_q;
                mark_phase_q <= ~mark_phase_q;
            end else begin
                tx_line_pos <= tx_data_pos;
                tx_line_neg <= tx_data_neg;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
    if (sys_rst) begin
        idle_cnt_q <= 8'h00;
        drive_failure_flag <= 1'b0;
    end else if (line_pulse) begin
        // Any detected pulse ends the failure at once
        idle_cnt_q <= 8'h00;
        drive_failure_flag <= 1'b0;
    end else if (tx_rise) begin
        if (idle_cnt_q != DRV_CNT[7:0] - 8'h01) begin
            idle_cnt_q <= idle_cnt_q + 8'h01;
        end else begin
            drive_failure_flag <= 1'b1;
        end
    end
end

endmodule

// >>> rtl/lmac_top.v
`timescale 1ns/10ps
`include "lmac_map.vh"


module lmac_top #(
    parameter NCH = 4,
    parameter DRV_CNT = `LMAC_DRV_MON_CNT,
    parameter LOS_E3 = `LMAC_LOS_E3_ZEROS,
    parameter LOS_DS3 = `LMAC_LOS_DS3_ZEROS,
    parameter LOL_WIN = `LMAC_LOL_WINDOW,
    parameter LOL_PERMILLE = `LMAC_LOL_TOL_PERMILLE
) (
    input wire clk,
    input wire sys_rst,
    input wire config_source_select,
    input wire [NCH-1:0] e3_rate_select,
    input wire [NCH-1:0] rate_select,
    input wire [NCH-1:0] all_ones_request,
    input wire [NCH-1:0] transmit_clock,
    input wire [NCH-1:0] tx_data_pos,
    input wire [NCH-1:0] tx_data_neg,
    input wire [NCH-1:0] monitor_tip_input,
    input wire [NCH-1:0] monitor_ring_input,
    input wire [NCH-1:0] recovered_clock,
    input wire [NCH-1:0] rx_data_pos,
    input wire [NCH-1:0] rx_data_neg,
    input wire [NCH-1:0] reference_clock_input,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg host_port_enable,
    output wire [NCH-1:0] tx_line_pos,
    output wire [NCH-1:0] tx_line_neg,
    output wire [NCH-1:0] drive_failure_flag,
    output reg [NCH-1:0] signal_loss_flag,
    output reg [NCH-1:0] lock_loss_flag,
    output reg [NCH-1:0] sts1_active,
    output reg [NCH-1:0] e3_active
);

localparam LOL_TOL = (LOL_WIN * LOL_PERMILLE) / 1000;
localparam [12:0] LOL_WIN_W = LOL_WIN;
localparam [12:0] LOL_TOL_W = LOL_TOL;
localparam [7:0] LOS_E3_W = LOS_E3;
localparam [7:0] LOS_DS3_W = LOS_DS3;
// Reset image of the control word, sliced per field below
localparam [11:0] CTRL_RST_W = `LMAC_CTRL_RST;

// Bus states
localparam ST_IDLE = 1'b0;
localparam ST_ACK = 1'b1;

////////////////////////////////////////////////////////////////////////////////
// Choose between host register and discrete pin per source mode
function pick_src;
    input host;
    input reg_bit;
    input pin_bit;
    begin
        pick_src = host ? reg_bit : pin_bit;
    end
endfunction

// Rising edge of a level sampled on clk
function rise;
    input now;
    input prev;
    begin
        rise = now & ~prev;
    end
endfunction

// Zero-run limit per rate; E3 trips on a shorter run
function [7:0] los_limit;
    input e3;
    input [7:0] e3_lim;
    input [7:0] ds3_lim;
    begin
        los_limit = e3 ? e3_lim : ds3_lim;
    end
endfunction

// Distance of a count from the window length, either side
function [12:0] abs_diff;
    input [12:0] a;
    input [12:0] b;
    begin
        abs_diff = (a > b) ? a - b : b - a;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
reg host_mode_q;
reg [NCH-1:0] host_e3_q;
reg [NCH-1:0] host_sts1_q;
reg [NCH-1:0] host_aone_q;
reg [NCH-1:0] aone_q;
reg bus_state_q;
reg [31:0] rd_d;
wire req;
wire [NCH-1:0] e3_eff;
wire [NCH-1:0] sts1_eff;
wire [NCH-1:0] aone_eff;
wire ctrl_wr;

assign req = avs_read | avs_write;
// Write strobe only in the answer cycle, while the master still holds it
assign ctrl_wr = (bus_state_q == ST_ACK) & avs_write &
                 (avs_address == `LMAC_CTRL_OFS);

// Mode pin taken every cycle; the serial port follows it
always @(posedge clk) begin
    if (sys_rst) begin
        host_mode_q <= 1'b0;
        host_port_enable <= 1'b0;
    end else begin
        host_mode_q <= config_source_select;
        host_port_enable <= config_source_select;
    end
end

genvar g;
generate
    for (g = 0; g < NCH; g = g + 1) begin : g_sel
        assign e3_eff[g] = pick_src(host_mode_q, host_e3_q[g], e3_rate_select[g]);
        // Rate pin counts only for non-E3 channels in hardware mode
        assign sts1_eff[g] = ~e3_eff[g] &
            pick_src(host_mode_q, host_sts1_q[g], rate_select[g]);
        assign aone_eff[g] = pick_src(host_mode_q, host_aone_q[g],
            all_ones_request[g]);
    end
endgenerate

always @(posedge clk) begin
    if (sys_rst) begin
        e3_active <= {NCH{1'b0}};
        sts1_active <= {NCH{1'b0}};
        aone_q <= {NCH{1'b0}};
    end else begin
        e3_active <= e3_eff;
        sts1_active <= sts1_eff;
        aone_q <= aone_eff;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Avalon-MM slave: one wait cycle, then the answer
always @* begin
    rd_d = 32'h00000000;
    case (avs_address)
        `LMAC_CTRL_OFS: begin
            rd_d[`LMAC_CTRL_E3_LSB +: NCH] = host_e3_q;
            rd_d[`LMAC_CTRL_STS1_LSB +: NCH] = host_sts1_q;
            rd_d[`LMAC_CTRL_AONE_LSB +: NCH] = host_aone_q;
        end
        `LMAC_STAT_OFS: begin
            rd_d[`LMAC_STAT_LOS_LSB +: NCH] = signal_loss_flag;
            rd_d[`LMAC_STAT_LOL_LSB +: NCH] = lock_loss_flag;
            rd_d[`LMAC_STAT_DRV_LSB +: NCH] = drive_failure_flag;
            rd_d[`LMAC_STAT_HOST_BIT] = host_mode_q;
        end
        `LMAC_MODE_OFS: begin
            rd_d[`LMAC_MODE_E3_LSB +: NCH] = e3_active;
            rd_d[`LMAC_MODE_STS1_LSB +: NCH] = sts1_active;
            rd_d[`LMAC_MODE_AONE_LSB +: NCH] = aone_q;
        end
        default: begin
            rd_d = 32'h00000000;
        end
    endcase
end

always @(posedge clk) begin
    if (sys_rst) begin
        bus_state_q <= ST_IDLE;
        avs_waitrequest <= 1'b1;
        avs_readdata <= 32'h00000000;
    end else begin
        case (bus_state_q)
            ST_IDLE: begin
                if (req) begin
                    bus_state_q <= ST_ACK;
                    avs_waitrequest <= 1'b0;
                    avs_readdata <= avs_read ? rd_d : 32'h00000000;
                end
            end
            ST_ACK: begin
                // A request held at this edge is not taken; the slave is busy
                bus_state_q <= ST_IDLE;
                avs_waitrequest <= 1'b1;
            end
            default: begin
                bus_state_q <= ST_IDLE;
                avs_waitrequest <= 1'b1;
            end
        endcase
    end
end

// Writes land at the edge where the master sees waitrequest low
always @(posedge clk) begin
    if (sys_rst) begin
        host_e3_q <= CTRL_RST_W[`LMAC_CTRL_E3_LSB +: NCH];
        host_sts1_q <= CTRL_RST_W[`LMAC_CTRL_STS1_LSB +: NCH];
        host_aone_q <= CTRL_RST_W[`LMAC_CTRL_AONE_LSB +: NCH];
    end else if (ctrl_wr) begin
        if (avs_byteenable[0]) begin
            host_e3_q <= avs_writedata[`LMAC_CTRL_E3_LSB +: NCH];
            host_sts1_q <= avs_writedata[`LMAC_CTRL_STS1_LSB +: NCH];
        end
        if (avs_byteenable[1]) begin
            host_aone_q <= avs_writedata[`LMAC_CTRL_AONE_LSB +: NCH];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Per-channel transmitter and drive monitor
generate
    for (g = 0; g < NCH; g = g + 1) begin : g_tx
        lmac_chan #(
            .DRV_CNT(DRV_CNT)
        ) u_chan (
            .clk(clk),
            .sys_rst(sys_rst),
            .all_ones(aone_q[g]),
            .transmit_clock(transmit_clock[g]),
            .tx_data_pos(tx_data_pos[g]),
            .tx_data_neg(tx_data_neg[g]),
            .monitor_tip_input(monitor_tip_input[g]),
            .monitor_ring_input(monitor_ring_input[g]),
            .tx_line_pos(tx_line_pos[g]),
            .tx_line_neg(tx_line_neg[g]),
            .drive_failure_flag(drive_failure_flag[g])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Loss of signal: a run of zeros on recovered clock edges
reg [NCH-1:0] rec_prev_q;
reg [NCH-1:0] ref_prev_q;

always @(posedge clk) begin
    // Sampled through reset, so release brings no false edge
    rec_prev_q <= recovered_clock;
    ref_prev_q <= reference_clock_input;
end

generate
    for (g = 0; g < NCH; g = g + 1) begin : g_los
        reg [7:0] zero_cnt_q;
        wire rec_edge;
        wire rx_mark;
        wire [7:0] limit;
        wire run_done;

        assign rec_edge = rise(recovered_clock[g], rec_prev_q[g]);
        assign rx_mark = rx_data_pos[g] | rx_data_neg[g];
        assign limit = los_limit(e3_active[g], LOS_E3_W, LOS_DS3_W);
        // Tested as a bound, so a shorter limit after a rate change cannot wrap
        assign run_done = (zero_cnt_q >= limit - 8'h01);

        always @(posedge clk) begin
            if (sys_rst) begin
                zero_cnt_q <= 8'h00;
                signal_loss_flag[g] <= 1'b0;
            end else if (rec_edge) begin
                if (rx_mark) begin
                    zero_cnt_q <= 8'h00;
                    signal_loss_flag[g] <= 1'b0;
                end else if (!run_done) begin
                    zero_cnt_q <= zero_cnt_q + 8'h01;
                end else begin
                    signal_loss_flag[g] <= 1'b1;
                end
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Loss of lock: count recovered edges over a window of reference edges.
// A stopped reference freezes the verdict; the window is the trade for 0.5%.
generate
    for (g = 0; g < NCH; g = g + 1) begin : g_lol
        reg [12:0] ref_cnt_q;
        reg [12:0] rec_cnt_q;
        wire ref_edge;
        wire rec_edge;
        wire [12:0] rec_total;
        wire [12:0] diff;
        wire win_end;
        wire off_freq;

        assign ref_edge = rise(reference_clock_input[g], ref_prev_q[g]);
        assign rec_edge = rise(recovered_clock[g], rec_prev_q[g]);
        assign rec_total = rec_cnt_q + {12'h000, rec_edge};
        assign diff = abs_diff(rec_total, LOL_WIN_W);
        // Window closes on the last reference rise; judge, then start afresh
        assign win_end = ref_edge && (ref_cnt_q == LOL_WIN_W - 13'h0001);
        assign off_freq = (diff > LOL_TOL_W);

        always @(posedge clk) begin
            if (sys_rst) begin
                ref_cnt_q <= 13'h0000;
                rec_cnt_q <= 13'h0000;
                lock_loss_flag[g] <= 1'b0;
            end else if (win_end) begin
                ref_cnt_q <= 13'h0000;
                rec_cnt_q <= 13'h0000;
                lock_loss_flag[g] <= off_freq;
            end else begin
                if (ref_edge) begin
                    ref_cnt_q <= ref_cnt_q + 13'h0001;
                end
                // Saturate so a runaway clock cannot wrap into range
                if (rec_edge && rec_cnt_q != 13'h1FFF) begin
                    rec_cnt_q <= rec_cnt_q + 13'h0001;
                end
            end
        end
    end
endgenerate

endmodule

// >>> test/lmac_chk_assertions.sv
`timescale 1ns/10ps
module lmac_chk #(
    parameter DRV_CNT = 128,
    parameter LOS_E3 = 32,
    parameter LOS_DS3 = 175
) (
    input wire clk,
    input wire sys_rst,
    input wire config_source_select,
    input wire [3:0] e3_rate_select,
    input wire [3:0] rate_select,
    input wire [3:0] all_ones_request,
    input wire [3:0] transmit_clock,
    input wire [3:0] monitor_tip_input,
    input wire [3:0] monitor_ring_input,
    input wire [3:0] recovered_clock,
    input wire [3:0] rx_data_pos,
    input wire [3:0] rx_data_neg,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire host_port_enable,
    input wire [3:0] tx_line_pos,
    input wire [3:0] tx_line_neg,
    input wire [3:0] drive_failure_flag,
    input wire [3:0] signal_loss_flag,
    input wire [3:0] sts1_active,
    input wire [3:0] e3_active
);
    reg tx_q;
    reg rc_q;
    reg [15:0] dcnt_q;
    reg [15:0] zcnt_q;
    wire pulse0 = monitor_tip_input[0] != monitor_ring_input[0];
    wire rrise = recovered_clock[0] && !rc_q;
    wire [15:0] los_lim = e3_active[0] ? LOS_E3 : LOS_DS3;
    // Channel 0 only: the others share the same logic
    always @(posedge clk) begin
        tx_q <= transmit_clock[0];
        rc_q <= recovered_clock[0];
        if (sys_rst || pulse0)
            dcnt_q <= 16'h0000;
        else if (transmit_clock[0] && !tx_q)
            dcnt_q <= dcnt_q + 16'h0001;
        if (sys_rst || (rrise && (rx_data_pos[0] || rx_data_neg[0])))
            zcnt_q <= 16'h0000;
        else if (rrise)
            zcnt_q <= zcnt_q + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    host_lag_a: assert property (!$past(sys_rst) |->
        host_port_enable == $past(config_source_select)) else $error("host enable lag");
    ack_one_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("ack too long");
    ack_due_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no ack");
    mode_hw_a: assert property ((!config_source_select && $stable(e3_rate_select)
        && $stable(rate_select))[*4] |-> e3_active == e3_rate_select
        && sts1_active == (rate_select & ~e3_rate_select)) else $error("hardware config");
    drv_set_a: assert property ($rose(drive_failure_flag[0]) |->
        dcnt_q == DRV_CNT || dcnt_q == DRV_CNT + 1) else $error("drive flag early or late");
    drv_clr_a: assert property (pulse0 |-> ##[1:3] !drive_failure_flag[0])
        else $error("drive flag not cleared");
    drv_keep_a: assert property ($fell(drive_failure_flag[0]) |-> dcnt_q < 2)
        else $error("drive flag dropped");
    aone_mark_a: assert property ((!config_source_select && all_ones_request[0])[*8] |->
        tx_line_pos[0] != tx_line_neg[0]) else $error("all-ones space");
    los_set_a: assert property ($rose(signal_loss_flag[0]) |->
        zcnt_q == los_lim || zcnt_q == los_lim + 16'h0001) else $error("loss count");
    los_clr_a: assert property ($fell(signal_loss_flag[0]) |-> zcnt_q == 16'h0000)
        else $error("loss cleared without mark");
endmodule

bind lmac_top lmac_chk #(.DRV_CNT(DRV_CNT), .LOS_E3(LOS_E3), .LOS_DS3(LOS_DS3)) u_lmac_chk (.*);

// >>> test/lmac_far.sv
`timescale 1ns/10ps
module lmac_far (
    input wire clk,
    input wire [3:0] rec_div,
    input wire [3:0] tx_line_pos,
    input wire [3:0] tx_line_neg,
    output wire [3:0] transmit_clock,
    output wire [3:0] recovered_clock,
    output wire [3:0] reference_clock_input,
    output wire [3:0] monitor_tip_input,
    output wire [3:0] monitor_ring_input
);
    reg [1:0] tx_q;
    reg [2:0] ref_q;
    reg [3:0] rec_q;
    initial begin
        tx_q = 2'h0;
        ref_q = 3'h0;
        rec_q = 4'h0;
    end
    // Recovered rate follows rec_div so a frequency offset can be dialled in
    always @(posedge clk) begin
        tx_q <= tx_q + 2'h1;
        ref_q <= ref_q + 3'h1;
        rec_q <= (rec_q >= rec_div - 4'h1) ? 4'h0 : rec_q + 4'h1;
    end
    assign transmit_clock = {4{tx_q[1]}};
    assign reference_clock_input = {4{ref_q[2]}};
    assign recovered_clock = {4{rec_q < 4'h3}};
    // Monitor leads wired back from the line outputs
    assign monitor_tip_input = tx_line_pos;
    assign monitor_ring_input = tx_line_neg;
endmodule

// >>> test/tb_lmac_top.sv
`timescale 1ns/10ps
module tb_lmac_top;
    reg clk;
    reg sys_rst;
    reg config_source_select;
    reg [3:0] e3_pin, rate_pin, aone_pin, rx_pos, rec_div, avs_address, rx_neg, be;
    reg avs_read, avs_write;
    reg [31:0] avs_writedata;
    reg [7:0] lfsr_q;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [3:0] txc, recc, refc, tip, ring, tx_pos, tx_neg;
    integer num_errors, compares, i;
    reg [31:0] exp_q[$];
    reg [31:0] msk_q[$];
    lmac_top #(.LOS_E3(4), .LOS_DS3(8), .LOL_WIN(200)) u_lmac_top (
        .clk(clk), .sys_rst(sys_rst), .config_source_select(config_source_select),
        .e3_rate_select(e3_pin), .rate_select(rate_pin), .all_ones_request(aone_pin),
        .transmit_clock(txc), .tx_data_pos(4'h0), .tx_data_neg(4'h0),
        .monitor_tip_input(tip), .monitor_ring_input(ring), .recovered_clock(recc),
        .rx_data_pos(rx_pos), .rx_data_neg(rx_neg), .reference_clock_input(refc),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .host_port_enable(), .tx_line_pos(tx_pos),
        .tx_line_neg(tx_neg), .drive_failure_flag(), .signal_loss_flag(),
        .lock_loss_flag(), .sts1_active(), .e3_active());
    lmac_far u_lmac_far (.clk(clk), .rec_div(rec_div), .tx_line_pos(tx_pos),
        .tx_line_neg(tx_neg), .transmit_clock(txc), .recovered_clock(recc),
        .reference_clock_input(refc), .monitor_tip_input(tip), .monitor_ring_input(ring));
    ////////////////////////////////////////////////////////////////
    function [7:0] lfsr(input [7:0] v);
        lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task check(input [8*5:1] name, input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("Error %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task bus(input we, input [3:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_read <= !we;
            avs_write <= we;
            n = 0;
            @(posedge clk);
            while (avs_waitrequest !== 1'b0 && n < 50) begin
                n = n + 1;
                @(posedge clk);
            end
            if (n == 50)
                check("ack", 32'h0, 32'h1);
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [31:0] e, input [31:0] m);
        begin
            exp_q.push_back(e & m);
            msk_q.push_back(m);
            bus(1'b0, a, 32'h0);
        end
    endtask
    task complete_run;
        begin
            $display("Checks %0d errors %0d", compares, num_errors);
            if (num_errors == 0 && compares > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk)
        if (avs_read && avs_waitrequest === 1'b0)
            check("rdata", avs_readdata & msk_q.pop_front(), exp_q.pop_front());
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #80000;
        num_errors = num_errors + 1;
        complete_run;
    end
    initial begin
        num_errors = 0;
        compares = 0;
        sys_rst = 1'b1;
        config_source_select = 1'b0;
        {e3_pin, rate_pin, aone_pin, rx_pos, rec_div} = 20'h10008;
        rx_neg = 4'h0;
        be = 4'hF;
        {avs_address, avs_read, avs_write, avs_writedata} = 38'h0;
        lfsr_q = 8'h46;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        tick(380);
        rd(4'h4, 32'h0, 32'hF00);
        tick(200);
        rd(4'h4, 32'hF00, 32'hF00);
        aone_pin <= 4'h1;
        tick(30);
        rd(4'h4, 32'hE00, 32'hF00);
        rd(4'h8, 32'h101, 32'hFFF);
        tick(100);
        rd(4'h4, 32'hE00, 32'hF00);
        $display("Drive monitor test done");
        rx_pos <= 4'h5;
        rx_neg <= 4'hA;
        tick(30);
        rd(4'h4, 32'h0, 32'hF);
        rx_pos <= 4'h0;
        rx_neg <= 4'h0;
        tick(44);
        rd(4'h4, 32'h1, 32'hF);
        tick(40);
        rd(4'h4, 32'hF, 32'hF);
        $display("Signal loss test done");
        for (i = 0; i < 4; i = i + 1) begin
            lfsr_q = lfsr(lfsr_q);
            e3_pin <= lfsr_q[3:0];
            rate_pin <= lfsr_q[7:4];
            tick(4);
            rd(4'h8, {20'h1, lfsr_q[7:4] & ~lfsr_q[3:0], lfsr_q[3:0]}, 32'hFFF);
        end
        rd(4'h4, 32'h0, 32'h1000);
        config_source_select <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            lfsr_q = lfsr(lfsr_q);
            e3_pin <= ~lfsr_q[3:0];
            bus(1'b1, 4'h0, {20'h0, lfsr_q[3:0], lfsr_q[7:4], lfsr_q[3:0]});
            tick(4);
            rd(4'h8, {20'h0, lfsr_q[3:0], lfsr_q[7:4] & ~lfsr_q[3:0], lfsr_q[3:0]}, 32'hFFF);
            rd(4'h0, {20'h0, lfsr_q[3:0], lfsr_q[7:4], lfsr_q[3:0]}, 32'hFFF);
        end
        rd(4'h4, 32'h1000, 32'h1000);
        be <= 4'h1;
        bus(1'b1, 4'h0, 32'h0);
        be <= 4'hF;
        rd(4'h0, {20'h0, lfsr_q[3:0], 8'h00}, 32'hFFF);
        bus(1'b1, 4'hC, 32'hFFFF);
        rd(4'hC, 32'h0, 32'hFFFFFFFF);
        $display("Mode test done");
        tick(1700);
        rd(4'h4, 32'h0, 32'hF0);
        rec_div <= 4'h7;
        tick(3400);
        rd(4'h4, 32'hF0, 32'hF0);
        rec_div <= 4'h8;
        tick(3400);
        rd(4'h4, 32'h0, 32'hF0);
        $display("Lock loss test done");
        tick(4);
        complete_run;
    end
endmodule
